// ### ptf_map.svh
/*
  Constants for the time-of-day feed: timing, field positions and reset values.
  Assumes the including file is compiled after ptf_pkg.sv or on its own.
*/
`ifndef PTF_MAP_SVH
`define PTF_MAP_SVH

// ----------------------------------------------------------------------
// Clock and time units
// ----------------------------------------------------------------------
`define PTF_CLK_PERIOD_NS   32'h0000_0005
`define PTF_NS_PER_SEC      33'h0_3b9a_ca00
`define PTF_RST_INC_NS      (`PTF_CLK_PERIOD_NS)
`define PTF_RST_INC_FRAC    16'h0000

// ----------------------------------------------------------------------
// Wide (96-bit) value layout: seconds, nanoseconds, fraction
// ----------------------------------------------------------------------
`define PTF_WIDE_SEC_MSB    95
`define PTF_WIDE_SEC_LSB    48
`define PTF_WIDE_NS_MSB     47
`define PTF_WIDE_NS_LSB     16
`define PTF_WIDE_FRAC_MSB   15
`define PTF_WIDE_FRAC_LSB   0

// ----------------------------------------------------------------------
// Narrow (64-bit) value layout: total nanoseconds, fraction
// ----------------------------------------------------------------------
`define PTF_NARROW_NS_MSB   63
`define PTF_NARROW_NS_LSB   16

// ----------------------------------------------------------------------
// Side indices and reset-source indices
// ----------------------------------------------------------------------
`define PTF_SIDE_TX         0
`define PTF_SIDE_RX         1
`define PTF_RSRC_CSR        0
`define PTF_RSRC_TX         1
`define PTF_RSRC_RX         2

`endif

// ### ptf_pkg.sv
/*
  Types for the time-of-day feed: one time value and the whole module state.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ptf_pkg;

  // ----------------------------------------------------------------------
  // One running time value
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [47:0] sec;
    logic [31:0] ns;
    logic [47:0] ns_total;
    logic [15:0] frac;
  } ptf_tod_t;

  typedef enum logic [1:0] {
    PTF_FOL_HOLD,
    PTF_FOL_ALIGN,
    PTF_FOL_RUN
  } ptf_fol_t;

  // ----------------------------------------------------------------------
  // Whole module state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0]        rst_meta;
    logic [2:0]        rst_sync;
    ptf_tod_t [1:0]    tod;
    logic [1:0][31:0]  inc_ns;
    logic [1:0][15:0]  inc_frac;
    ptf_fol_t          fol;
    logic              realign;
    logic [1:0]        live;
    logic [1:0][95:0]  wide;
    logic [1:0][63:0]  narrow;
  } ptf_state_t;

endpackage : ptf_pkg

// ### ptf_tod_feed.sv
/*
  Time-of-day feed for a timestamping Ethernet core: a leader counter for the
  transmit side and an aligned follower counter for the receive side, each
  presenting a fresh wide and narrow time value on every clock.
  Assumes one clock for both sides and reset sources arriving as pins.
*/
`timescale 1ns/1ps
`include "ptf_map.svh"

// How it works
// R1 - Both counters advance and present a fresh time value on every clock cycle.
// R2 - Each side delivers a 96-bit wide value, a 64-bit narrow value, or both, as the format enables select.
// R3 - The core only has the inputs its format calls for, so a disabled format is driven as zero.
// R4 - Both formats share one alignment path, so the follower aligns both formats together.
// R5 - The leader counter feeds the transmit inputs and the follower counter feeds the receive inputs.
// R6 - A single leader may drive both sides through followers; here the transmit counter is that leader.
// R7 - The general reset of both counters comes from the core's register-port reset source.
// R8 - The receive period reset and follower-side reset come from the core's receive reset source.
// R9 - The transmit period reset and leader-side reset come from the core's transmit reset source.
// R10 - The transmit wide and narrow values map one-to-one onto the core's transmit time inputs.
// R11 - The receive wide and narrow values map one-to-one onto the core's receive time inputs.
// R12 - The transmit counter and leader side run on the clock the transmit path uses.
// R13 - The receive counter and follower side run on the clock the receive path uses.
// R14 - The core samples each value on every rising edge of its own path clock and stamps frames with it.
module ptf_tod_feed (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic         csr_rstn_in,
  input  wire logic         tx_rstn_in,
  input  wire logic         rx_rstn_in,
  input  wire logic         wide_enable,
  input  wire logic         narrow_enable,
  input  wire logic         load_valid,
  input  wire logic [47:0]  load_sec,
  input  wire logic [31:0]  load_ns,
  input  wire logic [47:0]  load_ns_total,
  input  wire logic         period_wr,
  input  wire logic         period_side,
  input  wire logic [31:0]  period_ns,
  input  wire logic [15:0]  period_frac,
  output logic      [95:0]  transmit_tod_wide_in,
  output logic      [63:0]  transmit_tod_narrow_in,
  output logic      [95:0]  receive_tod_wide_in,
  output logic      [63:0]  receive_tod_narrow_in,
  output logic              tx_tod_live,
  output logic              rx_tod_live,
  output logic              follower_aligned
);

  ptf_pkg::ptf_state_t st_q;
  ptf_pkg::ptf_state_t st_d;

  // ----------------------------------------------------------------------
  // Time arithmetic
  // ----------------------------------------------------------------------
  // One step of a counter: fraction carries into nanoseconds, nanoseconds
  // roll into seconds at one billion; the narrow total never rolls.
  function automatic ptf_pkg::ptf_tod_t tod_step(
    input ptf_pkg::ptf_tod_t t,
    input logic [31:0]       inc_ns,
    input logic [15:0]       inc_frac
  );
    logic [16:0]       f;
    logic [32:0]       n;
    ptf_pkg::ptf_tod_t r;
    f = {1'b0, t.frac} + {1'b0, inc_frac};
    n = {1'b0, t.ns} + {1'b0, inc_ns} + {32'h0000_0000, f[16]};
    r.frac     = f[15:0];
    r.ns_total = t.ns_total + {16'h0000, inc_ns} + {47'h0000_0000_0000, f[16]};
    if (n >= `PTF_NS_PER_SEC) begin
      n     = n - `PTF_NS_PER_SEC;
      r.ns  = n[31:0];
      r.sec = t.sec + 48'h0000_0000_0001;
    end else begin
      r.ns  = n[31:0];
      r.sec = t.sec;
    end
    return r;
  endfunction : tod_step

  function automatic logic [95:0] tod_wide(input ptf_pkg::ptf_tod_t t);
    logic [95:0] w;
    w = 96'h0;
    w[`PTF_WIDE_SEC_MSB:`PTF_WIDE_SEC_LSB]   = t.sec;
    w[`PTF_WIDE_NS_MSB:`PTF_WIDE_NS_LSB]     = t.ns;
    w[`PTF_WIDE_FRAC_MSB:`PTF_WIDE_FRAC_LSB] = t.frac;
    return w;
  endfunction : tod_wide

  function automatic logic [63:0] tod_narrow(input ptf_pkg::ptf_tod_t t);
    logic [63:0] w;
    w = 64'h0;
    w[`PTF_NARROW_NS_MSB:`PTF_NARROW_NS_LSB]   = t.ns_total;
    w[`PTF_WIDE_FRAC_MSB:`PTF_WIDE_FRAC_LSB]   = t.frac;
    return w;
  endfunction : tod_narrow

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic              csr_ok;
    logic [1:0]        side_ok;
    ptf_pkg::ptf_tod_t lead_next;
    csr_ok    = 1'b0;
    side_ok   = 2'b00;
    lead_next = '0;
    st_d      = st_q;

    // Reset pins are asynchronous to this clock; two stages before use
    st_d.rst_meta = {rx_rstn_in, tx_rstn_in, csr_rstn_in};
    st_d.rst_sync = st_q.rst_meta;
    csr_ok                   = st_q.rst_sync[`PTF_RSRC_CSR];                 // R7
    side_ok[`PTF_SIDE_TX]    = st_q.rst_sync[`PTF_RSRC_TX];                  // R9
    side_ok[`PTF_SIDE_RX]    = st_q.rst_sync[`PTF_RSRC_RX];                  // R8

    // Period registers: a side's period reset restores the default step
    for (int s = 0; s < 2; s++) begin
      if (!side_ok[s]) begin
        st_d.inc_ns[s]   = `PTF_RST_INC_NS;
        st_d.inc_frac[s] = `PTF_RST_INC_FRAC;
      end else if (period_wr && (period_side == s[0])) begin
        st_d.inc_ns[s]   = period_ns;
        st_d.inc_frac[s] = period_frac;
      end
    end

    // Leader: transmit counter, stepped every cycle it is out of reset and not being loaded
    lead_next = tod_step(st_q.tod[`PTF_SIDE_TX], st_q.inc_ns[`PTF_SIDE_TX],
                         st_q.inc_frac[`PTF_SIDE_TX]);                      // R1 R12
    if (!csr_ok) begin
      st_d.tod[`PTF_SIDE_TX] = '0;                                          // R7
    end else if (load_valid) begin
      st_d.tod[`PTF_SIDE_TX].sec      = load_sec;
      st_d.tod[`PTF_SIDE_TX].ns       = load_ns;
      st_d.tod[`PTF_SIDE_TX].ns_total = load_ns_total;
      st_d.tod[`PTF_SIDE_TX].frac     = 16'h0000;
    end else if (side_ok[`PTF_SIDE_TX]) begin
      st_d.tod[`PTF_SIDE_TX] = lead_next;                                   // R6 R9
    end

    // A load moves the leader, so the follower must be pulled back in
    if (load_valid || !side_ok[`PTF_SIDE_TX]) begin
      st_d.realign = 1'b1;
    end else if (st_q.fol == ptf_pkg::PTF_FOL_ALIGN) begin
      st_d.realign = 1'b0;
    end

    // Follower: receive counter, aligned to the leader then free-running
    unique case (st_q.fol)
      ptf_pkg::PTF_FOL_HOLD: begin
        if (csr_ok && side_ok[`PTF_SIDE_RX] && side_ok[`PTF_SIDE_TX]) begin
          st_d.fol = ptf_pkg::PTF_FOL_ALIGN;
        end
      end
      ptf_pkg::PTF_FOL_ALIGN: begin
        // Both formats copied in one go, so the two never disagree
        st_d.tod[`PTF_SIDE_RX] = lead_next;                                 // R4 R6
        st_d.fol               = ptf_pkg::PTF_FOL_RUN;
      end
      ptf_pkg::PTF_FOL_RUN: begin
        st_d.tod[`PTF_SIDE_RX] = tod_step(st_q.tod[`PTF_SIDE_RX], st_q.inc_ns[`PTF_SIDE_RX],
                                          st_q.inc_frac[`PTF_SIDE_RX]);    // R1 R13
        if (st_q.realign) begin
          st_d.fol = ptf_pkg::PTF_FOL_ALIGN;
        end
      end
    endcase
    // A side reset also cancels the step that RUN would take this cycle,
    // otherwise the receive value moves once more after the reset is seen
    if (!side_ok[`PTF_SIDE_RX] || !side_ok[`PTF_SIDE_TX]) begin
      st_d.fol               = ptf_pkg::PTF_FOL_HOLD;                       // R8
      st_d.tod[`PTF_SIDE_RX] = st_q.tod[`PTF_SIDE_RX];                      // R8
    end
    if (!csr_ok) begin
      st_d.tod[`PTF_SIDE_RX] = '0;                                          // R7
      st_d.fol               = ptf_pkg::PTF_FOL_HOLD;
    end

    // Outputs: formats not selected are held at zero
    st_d.live[`PTF_SIDE_TX] = csr_ok && side_ok[`PTF_SIDE_TX];
    st_d.live[`PTF_SIDE_RX] = csr_ok && (st_q.fol == ptf_pkg::PTF_FOL_RUN);
    for (int s = 0; s < 2; s++) begin
      st_d.wide[s]   = wide_enable   ? tod_wide(st_q.tod[s])   : 96'h0;    // R2 R3
      st_d.narrow[s] = narrow_enable ? tod_narrow(st_q.tod[s]) : 64'h0;    // R2 R3
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q          <= '0;
      st_q.inc_ns   <= {2{`PTF_RST_INC_NS}};
      st_q.inc_frac <= {2{`PTF_RST_INC_FRAC}};
      st_q.fol      <= ptf_pkg::PTF_FOL_HOLD;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------------
  // Core-facing outputs, all straight from the state register
  // ----------------------------------------------------------------------
  assign transmit_tod_wide_in   = st_q.wide[`PTF_SIDE_TX];                  // R5 R10 R14
  assign transmit_tod_narrow_in = st_q.narrow[`PTF_SIDE_TX];                // R10
  assign receive_tod_wide_in    = st_q.wide[`PTF_SIDE_RX];                  // R5 R11 R14
  assign receive_tod_narrow_in  = st_q.narrow[`PTF_SIDE_RX];                // R11
  assign tx_tod_live            = st_q.live[`PTF_SIDE_TX];
  assign rx_tod_live            = st_q.live[`PTF_SIDE_RX];
  assign follower_aligned       = (st_q.fol == ptf_pkg::PTF_FOL_RUN);

endmodule : ptf_tod_feed

// ### ptf_props.sv
/* Checker for the time-of-day feed ports.
   Assumes the bind below onto ptf_tod_feed. */
`timescale 1ns/1ps
module ptf_props (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        csr_rstn_in,
  input wire logic        tx_rstn_in,
  input wire logic        rx_rstn_in,
  input wire logic        wide_enable,
  input wire logic        narrow_enable,
  input wire logic        load_valid,
  input wire logic        period_wr,
  input wire logic [47:0] load_ns_total,
  input wire logic [95:0] transmit_tod_wide_in,
  input wire logic [63:0] transmit_tod_narrow_in,
  input wire logic [95:0] receive_tod_wide_in,
  input wire logic [63:0] receive_tod_narrow_in,
  input wire logic        tx_tod_live,
  input wire logic        rx_tod_live,
  input wire logic        follower_aligned
);
  // ------
  // Properties
  // ------
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_load;
    load_valid && tx_tod_live && narrow_enable ##1 !load_valid;
  endsequence
  sequence s_quiet;
    (!load_valid && !period_wr && tx_rstn_in && rx_rstn_in && csr_rstn_in) [*6];
  endsequence
  a_tx_fresh: assert property ((tx_rstn_in && csr_rstn_in && narrow_enable) [*5] ##0 tx_tod_live
    |-> transmit_tod_narrow_in != $past(transmit_tod_narrow_in)) else $error("tx value not fresh");
  a_wide_off: assert property (!wide_enable [*2]
    |-> transmit_tod_wide_in == 96'h0 && receive_tod_wide_in == 96'h0) else $error("wide not zero");
  a_narrow_off: assert property (!narrow_enable [*2]
    |-> transmit_tod_narrow_in == 64'h0 && receive_tod_narrow_in == 64'h0) else $error("narrow not zero");
  a_csr_clear: assert property (!csr_rstn_in [*5] |-> !tx_tod_live && transmit_tod_narrow_in == 64'h0
    && receive_tod_narrow_in == 64'h0) else $error("csr reset did not clear");
  a_tx_freeze: assert property ((!tx_rstn_in && csr_rstn_in && narrow_enable && !load_valid) [*5]
    |-> $stable(transmit_tod_narrow_in)) else $error("tx not frozen");
  a_rx_freeze: assert property ((!rx_rstn_in && csr_rstn_in && narrow_enable) [*5]
    |-> $stable(receive_tod_narrow_in)) else $error("rx not frozen");
  a_rx_tracks: assert property (s_quiet ##0 follower_aligned && rx_tod_live
    |-> receive_tod_narrow_in == transmit_tod_narrow_in) else $error("rx not tracking tx");
  a_load_lands: assert property (s_load |=> transmit_tod_narrow_in
    == {$past(load_ns_total, 2), 16'h0}) else $error("load not seen");
endmodule : ptf_props

bind ptf_tod_feed ptf_props u_props (.*);

// ### ptf_core_model.sv
/* Core side of the time inputs: latches every value on each clock.
   Assumes one clock shared by both paths. */
`timescale 1ns/1ps
module ptf_core_model (
  input  wire logic        clock,
  input  wire logic [95:0] tx_wide,
  input  wire logic [63:0] tx_narrow,
  input  wire logic [95:0] rx_wide,
  input  wire logic [63:0] rx_narrow,
  output logic      [95:0] st_tx_w,
  output logic      [63:0] st_tx_n,
  output logic      [95:0] st_rx_w,
  output logic      [63:0] st_rx_n
);
  // A frame stamped this cycle carries these
  always_ff @(posedge clock) begin
    st_tx_w <= tx_wide;
    st_tx_n <= tx_narrow;
    st_rx_w <= rx_wide;
    st_rx_n <= rx_narrow;
  end
endmodule : ptf_core_model

// ### ptf_tod_feed_tb_top.sv
/* Testbench: reference time counter compared with the feed.
   Assumes ptf_pkg, ptf_props and ptf_core_model compiled first. */
`timescale 1ns/1ps
module ptf_tod_feed_tb_top;
  logic        clock, resetn, csr_rstn_in, tx_rstn_in, rx_rstn_in;
  logic        wide_enable, narrow_enable, load_valid, period_wr, period_side;
  logic [47:0] load_sec, load_ns_total;
  logic [31:0] load_ns, period_ns;
  logic [15:0] period_frac;
  logic [95:0] transmit_tod_wide_in, receive_tod_wide_in, sw_tx, sw_rx;
  logic [63:0] transmit_tod_narrow_in, receive_tod_narrow_in, sn_tx, sn_rx, nt;
  logic        tx_tod_live, rx_tod_live, follower_aligned;
  int          n_mismatch, cmp_count, cyc, seed, e;
  longint      sec, ns, frac, sns, sfr;

  ptf_tod_feed dut (.*);
  ptf_core_model u_core (.clock(clock), .tx_wide(transmit_tod_wide_in),
    .tx_narrow(transmit_tod_narrow_in), .rx_wide(receive_tod_wide_in),
    .rx_narrow(receive_tod_narrow_in), .st_tx_w(sw_tx), .st_tx_n(sn_tx),
    .st_rx_w(sw_rx), .st_rx_n(sn_rx));

  // ------
  // Tasks
  // ------
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t time value mismatch", $time);
    end
  endtask : chk
  task automatic load(input longint s, input longint n, input logic [47:0] t);
    @(negedge clock);
    {load_valid, load_sec, load_ns, load_ns_total} = {1'b1, s[47:0], n[31:0], t};
    @(negedge clock);
    load_valid = 1'b0;
    @(negedge clock);
    {sec, ns, frac, nt} = {s, n, 64'h0, t, 16'h0};
  endtask : load
  // Stamps lag the outputs by one cycle
  task automatic run_cmp(input int n, input bit with_rx);
    repeat (n) begin
      @(negedge clock);
      chk(sw_tx, {sec[47:0], ns[31:0], frac[15:0]});
      chk({32'h0, sn_tx}, {32'h0, nt});
      if (with_rx) chk(sw_rx, {sec[47:0], ns[31:0], frac[15:0]});
      if (with_rx) chk({32'h0, sn_rx}, {32'h0, nt});
      frac += sfr;
      ns += sns + (frac >> 16);
      frac &= 'hffff;
      if (ns >= 1000000000) begin
        ns -= 1000000000;
        sec++;
      end
      nt += {sns[31:0], sfr[15:0]};
    end
  endtask : run_cmp
  task automatic scen(input int rollover);
    for (int i = 0; i < 60 && follower_aligned !== 1'b1; i++) @(negedge clock);
    load({16'h0, $random(seed)}, 1000000000 - rollover * sns, {16'h0, $random(seed)});
    run_cmp(6, 0);
    run_cmp(30, 1);
  endtask : scen
  task automatic close_out;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  // ------
  // Clock, timeout, sequence
  // ------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    {resetn, csr_rstn_in, tx_rstn_in, rx_rstn_in, load_valid, period_wr, period_side} = 7'h0;
    {wide_enable, narrow_enable, load_sec, load_ns, load_ns_total} = {2'h3, 128'h0};
    {period_ns, period_frac, n_mismatch, cmp_count, cyc} = 144'h0;
    seed = 18;
    sns = 1 + ($random(seed) & 15);
    sfr = $random(seed) & 'hffff;
    repeat (3) @(negedge clock);
    resetn = 1'b1;
    {tx_rstn_in, rx_rstn_in} = 2'h3;
    repeat (3) @(negedge clock);
    // Same step on both sides, written while values are held clear
    {period_wr, period_ns, period_frac} = {1'b1, sns[31:0], sfr[15:0]};
    @(negedge clock);
    period_side = 1'b1;
    @(negedge clock);
    period_wr = 1'b0;
    csr_rstn_in = 1'b1;
    scen(20);
    for (e = 0; e < 4; e++) begin
      {wide_enable, narrow_enable} = e[1:0];
      repeat (3) @(negedge clock);
      if (!wide_enable) chk(sw_tx | sw_rx, 96'h0);
      if (!narrow_enable) chk({32'h0, sn_tx | sn_rx}, 96'h0);
    end
    // Side resets restore the default step of 5 ns
    {tx_rstn_in, rx_rstn_in} = 2'h0;
    repeat (6) @(negedge clock);
    {tx_rstn_in, rx_rstn_in} = 2'h3;
    {sns, sfr} = {64'd5, 64'd0};
    scen(8);
    csr_rstn_in = 1'b0;
    repeat (6) @(negedge clock);
    chk({sn_tx, sn_rx}, 128'h0);
    close_out();
  end
endmodule : ptf_tod_feed_tb_top
